// file: design/batg_top.sv
// Register access over APB and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
module batg_top
  import batg_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Address generation request from the pipeline
  input wire logic ag_req,
  input wire logic ag_write,
  input wire logic ag_x_space,
  input wire logic ag_word,
  input wire logic [2:0] ag_mode,
  input wire logic [3:0] ag_reg_index,
  input wire logic [15:0] ag_pointer,
  input wire logic [15:0] ag_offset,
  input wire logic ag_modulo_en,
  // Address generation answer
  output logic ag_done,
  output logic [15:0] ag_eff_addr,
  output logic [15:0] ag_pointer_next,
  output logic ag_pointer_update,
  output logic ag_bitrev_used,
  output logic ag_modulo_apply,
  // Table access request
  input wire logic tbl_req,
  input wire logic [2:0] tbl_op,
  input wire logic tbl_byte,
  input wire logic [15:0] tbl_eff_addr,
  input wire logic [15:0] tbl_wdata,
  // Table access answer
  output logic tbl_rvalid,
  output logic [15:0] tbl_rdata,
  output logic tbl_refused,
  // Program memory port
  output logic prog_rd,
  output logic prog_wr,
  output logic [23:0] prog_addr,
  output logic prog_config,
  output logic [23:0] prog_wdata,
  output logic [2:0] prog_wmask,
  input wire logic [23:0] prog_rdata,
  // Program counter
  input wire logic pc_advance,
  input wire logic pc_load,
  input wire logic [23:0] pc_load_value,
  output logic [23:0] prog_counter
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [15:0] bitrev_control;
  logic [7:0] table_page;
  logic [3:0] bitrev_pointer_select;
  logic [23:0] pc_reg;
  logic last_config;
  logic rd_pend;
  logic [2:0] rd_op;
  logic rd_byte;
  logic rd_sel;

  wire bitrev_enable = bitrev_control[BATG_BITREV_ENABLE_BIT];
  wire [14:0] bitrev_pivot = bitrev_control[BATG_PIVOT_MSB:0];

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  wire hit_ctrl = (paddr == BATG_OFF_BITREV_CONTROL);
  wire hit_page = (paddr == BATG_OFF_TABLE_PAGE);
  wire hit_mode = (paddr == BATG_OFF_ADDR_MODE);
  wire hit_stat = (paddr == BATG_OFF_STATUS);
  wire hit_pc = (paddr == BATG_OFF_PROG_COUNTER);
  wire hit_any = hit_ctrl | hit_page | hit_mode | hit_stat | hit_pc;

  // Answer one cycle into the access phase; the write lands on the next edge, which samples pready high
  wire apb_access = psel & penable;
  wire apb_commit = apb_access & pready;
  wire apb_wr = apb_commit & pwrite & hit_any;
  wire next_pready = apb_access & ~pready;

  wire [31:0] status_word = {
    12'h000, rd_pend, last_config, ag_bitrev_used, ag_pointer_update, ag_eff_addr
  };

  wire [31:0] read_mux =
    hit_ctrl ? {16'h0000, bitrev_control} :
    hit_page ? {24'h000000, table_page} :
    hit_mode ? {20'h00000, bitrev_pointer_select, 8'h00} :
    hit_stat ? status_word :
    hit_pc ? {8'h00, pc_reg} : 32'h00000000;

  wire [31:0] next_prdata = (next_pready & ~pwrite) ? read_mux : 32'h00000000;
  wire next_pslverr = next_pready & ~hit_any;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= next_pready;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // Software-visible control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bitrev_control <= BATG_BITREV_CONTROL_RST;
      table_page <= BATG_TABLE_PAGE_RST;
      bitrev_pointer_select <= BATG_POINTER_SELECT_RST;
    end else if (apb_wr) begin
      if (hit_ctrl) begin
        bitrev_control <= pwdata[15:0];
      end
      if (hit_page) begin
        table_page <= pwdata[7:0];
      end
      if (hit_mode) begin
        bitrev_pointer_select <= pwdata[BATG_POINTER_SELECT_LSB+3:BATG_POINTER_SELECT_LSB];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data-space address generator; X-space word writes can take the reversed path

  wire sel_live = (bitrev_pointer_select != BATG_POINTER_SELECT_OFF);
  wire sel_match = sel_live & (ag_reg_index == bitrev_pointer_select);
  wire mode_pre_inc = (ag_mode == BATG_AM_PRE_INC);
  wire mode_post_inc = (ag_mode == BATG_AM_POST_INC);
  wire mode_pre_dec = (ag_mode == BATG_AM_PRE_DEC);
  wire mode_post_dec = (ag_mode == BATG_AM_POST_DEC);
  wire mode_inc = mode_pre_inc | mode_post_inc;
  wire mode_pre = mode_pre_inc | mode_pre_dec;
  wire mode_modify = mode_inc | mode_pre_dec | mode_post_dec;

  // Reads, Y space and byte data never take the reversed path
  wire bitrev_path = ag_write & ag_x_space & ag_word;
  wire bitrev_active = bitrev_enable & sel_match & mode_inc & bitrev_path;

  // Pivot counts words, so it is doubled to a byte step
  wire [15:0] pivot_bytes = {bitrev_pivot, 1'b0};
  wire [15:0] rev_raw;

  // Pointer stays in normal order; only the modifier is reversed in effect
  batg_revcarry_add #(
    .WIDTH(16)
  ) u_revadd (
    .augend(ag_pointer),
    .addend(pivot_bytes),
    .sum(rev_raw)
  );

  wire [15:0] rev_next = {rev_raw[15:1], 1'b0};
  wire [15:0] ptr_even = {ag_pointer[15:1], 1'b0};

  wire [15:0] ptr_plus = ag_pointer + ag_offset;
  wire [15:0] ptr_minus = ag_pointer - ag_offset;
  wire [15:0] normal_mod = (mode_pre_dec | mode_post_dec) ? ptr_minus :
                           (mode_inc ? ptr_plus : ag_pointer);

  // The indirect offset is dropped whenever reversal is in force
  wire [15:0] next_ptr = bitrev_active ? rev_next : normal_mod;
  wire [15:0] next_eff = bitrev_active ? (mode_pre ? rev_next : ptr_even) :
                         (mode_pre ? normal_mod : ag_pointer);

  // Modulo correction is left to the modulo logic and only flagged here
  wire next_modulo_apply = ag_req & ag_modulo_en & ~bitrev_active;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ag_done <= 1'b0;
      ag_eff_addr <= 16'h0000;
      ag_pointer_next <= 16'h0000;
      ag_pointer_update <= 1'b0;
      ag_bitrev_used <= 1'b0;
      ag_modulo_apply <= 1'b0;
    end else begin
      ag_done <= ag_req;
      ag_modulo_apply <= next_modulo_apply;
      if (ag_req) begin
        ag_eff_addr <= next_eff;
        ag_pointer_next <= next_ptr;
        ag_pointer_update <= mode_modify;
        ag_bitrev_used <= bitrev_active;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Table access to program space

  // Page forms the upper byte; no alignment is imposed on the low half
  wire [23:0] tbl_prog_addr = {table_page, tbl_eff_addr};
  wire tbl_in_config = table_page[BATG_CONFIG_SPACE_BIT];
  wire byte_sel = tbl_eff_addr[0];

  wire op_rd_low = (tbl_op == BATG_TOP_READ_LOW);
  wire op_rd_high = (tbl_op == BATG_TOP_READ_HIGH);
  wire op_wr_low = (tbl_op == BATG_TOP_WRITE_LOW);
  wire op_wr_high = (tbl_op == BATG_TOP_WRITE_HIGH);
  wire op_win_rd = (tbl_op == BATG_TOP_WINDOW_READ);
  wire op_win_wr = (tbl_op == BATG_TOP_WINDOW_WRITE);

  // Reads are allowed in configuration space as well as user space
  wire next_prog_rd = tbl_req & (op_rd_low | op_rd_high | op_win_rd);
  wire next_prog_wr = tbl_req & (op_wr_low | op_wr_high);
  // The window cannot be written and unknown codes are not executed
  wire next_refused = tbl_req & ~next_prog_rd & ~next_prog_wr;

  // Low writes reach bits 15:0, high writes only bits 23:16
  wire [2:0] mask_low = tbl_byte ? (byte_sel ? 3'h2 : 3'h1) : 3'h3;
  wire [2:0] mask_high = (tbl_byte & byte_sel) ? 3'h0 : 3'h4;
  wire [2:0] next_wmask = op_wr_high ? mask_high : (op_wr_low ? mask_low : 3'h0);
  wire [23:0] next_wdata = tbl_byte ?
    {tbl_wdata[7:0], tbl_wdata[7:0], tbl_wdata[7:0]} :
    {tbl_wdata[7:0], tbl_wdata[15:0]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_rd <= 1'b0;
      prog_wr <= 1'b0;
      prog_addr <= 24'h000000;
      prog_config <= 1'b0;
      prog_wdata <= 24'h000000;
      prog_wmask <= 3'h0;
      tbl_refused <= 1'b0;
    end else begin
      prog_rd <= next_prog_rd;
      prog_wr <= next_prog_wr;
      tbl_refused <= next_refused;
      if (tbl_req) begin
        prog_addr <= tbl_prog_addr;
        prog_config <= tbl_in_config;
        prog_wdata <= next_wdata;
        prog_wmask <= next_wmask;
      end
    end
  end

  // Shape of the read in flight, held for the data-return cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_pend <= 1'b0;
      rd_op <= 3'h0;
      rd_byte <= 1'b0;
      rd_sel <= 1'b0;
      last_config <= 1'b0;
    end else begin
      rd_pend <= next_prog_rd;
      if (next_prog_rd) begin
        rd_op <= tbl_op;
        rd_byte <= tbl_byte & ~op_win_rd;
        rd_sel <= byte_sel;
      end
      if (tbl_req) begin
        last_config <= tbl_in_config;
      end
    end
  end

  wire [15:0] mapped_data;

  batg_table_map u_map (
    .op(rd_op),
    .byte_mode(rd_byte),
    .byte_select(rd_sel),
    .prog_word(prog_rdata),
    .data(mapped_data)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tbl_rvalid <= 1'b0;
      tbl_rdata <= 16'h0000;
    end else begin
      tbl_rvalid <= rd_pend;
      if (rd_pend) begin
        tbl_rdata <= mapped_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program counter

  // Instruction fetches stay in user space on even addresses
  wire [23:0] pc_sum = pc_reg + BATG_PC_STEP;
  wire [23:0] next_pc = pc_load ? {1'b0, pc_load_value[22:1], 1'b0} :
                        (pc_advance ? {1'b0, pc_sum[22:1], 1'b0} : pc_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_reg <= BATG_PROG_COUNTER_RST;
    end else begin
      pc_reg <= next_pc;
    end
  end

  assign prog_counter = pc_reg;

endmodule
`default_nettype wire

// file: design/batg_pkg.sv
package batg_pkg;

  // Register byte offsets on the APB side
  localparam logic [7:0] BATG_OFF_BITREV_CONTROL = 8'h00;
  localparam logic [7:0] BATG_OFF_TABLE_PAGE = 8'h04;
  localparam logic [7:0] BATG_OFF_ADDR_MODE = 8'h08;
  localparam logic [7:0] BATG_OFF_STATUS = 8'h0C;
  localparam logic [7:0] BATG_OFF_PROG_COUNTER = 8'h10;

  // Values after reset
  localparam logic [15:0] BATG_BITREV_CONTROL_RST = 16'h0000;
  localparam logic [7:0] BATG_TABLE_PAGE_RST = 8'h00;
  localparam logic [3:0] BATG_POINTER_SELECT_RST = 4'hF;
  localparam logic [23:0] BATG_PROG_COUNTER_RST = 24'h000000;

  // Field positions
  localparam int BATG_BITREV_ENABLE_BIT = 15;
  localparam int BATG_PIVOT_MSB = 14;
  localparam int BATG_POINTER_SELECT_LSB = 8;
  localparam int BATG_CONFIG_SPACE_BIT = 7;

  // Pointer select code that disables bit reversal (stack pointer)
  localparam logic [3:0] BATG_POINTER_SELECT_OFF = 4'hF;

  // One program word spans two data-space addresses
  localparam logic [23:0] BATG_PC_STEP = 24'h000002;

  typedef enum logic [2:0] {
    BATG_AM_INDIRECT = 3'h0,
    BATG_AM_POST_INC = 3'h1,
    BATG_AM_PRE_INC = 3'h2,
    BATG_AM_POST_DEC = 3'h3,
    BATG_AM_PRE_DEC = 3'h4,
    BATG_AM_OTHER = 3'h5
  } batg_mode_t;

  typedef enum logic [2:0] {
    BATG_TOP_READ_LOW = 3'h0,
    BATG_TOP_READ_HIGH = 3'h1,
    BATG_TOP_WRITE_LOW = 3'h2,
    BATG_TOP_WRITE_HIGH = 3'h3,
    BATG_TOP_WINDOW_READ = 3'h4,
    BATG_TOP_WINDOW_WRITE = 3'h5
  } batg_table_op_t;

endpackage

// file: design/batg_revcarry_add.sv
`timescale 1ns/100ps
`default_nettype none
module batg_revcarry_add #(
  parameter int WIDTH = 16
) (
  // Operands
  input wire logic [WIDTH-1:0] augend,
  input wire logic [WIDTH-1:0] addend,
  // Result
  output logic [WIDTH-1:0] sum
);

  logic [WIDTH:0] carry;

  // Carries run from the top bit downward; the carry out of bit 0 is dropped
  assign carry[WIDTH] = 1'b0;

  generate
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      assign sum[i] = augend[i] ^ addend[i] ^ carry[i+1];
      assign carry[i] = (augend[i] & addend[i]) | (carry[i+1] & (augend[i] ^ addend[i]));
    end
  endgenerate

  initial begin
    if (WIDTH < 2) begin
      $error("batg_revcarry_add: WIDTH must be at least 2");
    end
  end

endmodule
`default_nettype wire

// file: design/batg_table_map.sv
`timescale 1ns/100ps
`default_nettype none
module batg_table_map
  import batg_pkg::*;
(
  // Read request shape
  input wire logic [2:0] op,
  input wire logic byte_mode,
  input wire logic byte_select,
  // Program word as fetched
  input wire logic [23:0] prog_word,
  // Data-space value
  output logic [15:0] data
);

  wire is_high = (op == BATG_TOP_READ_HIGH);
  wire is_window = (op == BATG_TOP_WINDOW_READ);
  wire [7:0] low_pick = byte_select ? prog_word[15:8] : prog_word[7:0];
  wire [7:0] high_pick = byte_select ? 8'h00 : prog_word[23:16];
  wire [15:0] low_val = byte_mode ? {8'h00, low_pick} : prog_word[15:0];
  wire [15:0] high_val = byte_mode ? {8'h00, high_pick} : {8'h00, prog_word[23:16]};

  // The window only ever shows the low word of a program word
  assign data = is_window ? prog_word[15:0] : (is_high ? high_val : low_val);

endmodule
`default_nettype wire

// file: testbench/batg_checker_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module batg_checker
  import batg_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Address generator
  input wire logic ag_req,
  input wire logic ag_write,
  input wire logic ag_x_space,
  input wire logic ag_word,
  input wire logic [2:0] ag_mode,
  input wire logic ag_done,
  input wire logic [15:0] ag_eff_addr,
  input wire logic [15:0] ag_pointer_next,
  input wire logic ag_bitrev_used,
  input wire logic ag_modulo_apply,
  // Table access and program memory
  input wire logic tbl_req,
  input wire logic [2:0] tbl_op,
  input wire logic [15:0] tbl_eff_addr,
  input wire logic tbl_rvalid,
  input wire logic tbl_refused,
  input wire logic prog_rd,
  input wire logic prog_wr,
  input wire logic [23:0] prog_addr,
  input wire logic prog_config,
  input wire logic [2:0] prog_wmask,
  // Program counter
  input wire logic pc_advance,
  input wire logic pc_load,
  input wire logic [23:0] prog_counter
);
  // Requests on the first edge after release may be dropped, so wait three edges
  logic [1:0] live;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      live <= 2'h0;
    end else if (live != 2'h3) begin
      live <= live + 2'h1;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  //////////////////////////////
  sequence s_tbl_read;
    prog_rd ##1 tbl_rvalid;
  endsequence
  sequence s_rev_done;
    ag_done && ag_bitrev_used;
  endsequence
  a_rev_writes_only: assert property (
    ag_req && !(ag_write && ag_x_space) |=> !ag_bitrev_used) else $error("reversed read");
  a_rev_modes_only: assert property (
    ag_req && (!ag_word || (ag_mode != BATG_AM_POST_INC && ag_mode != BATG_AM_PRE_INC))
    |=> !ag_bitrev_used) else $error("reversed in wrong mode");
  a_rev_even_addr: assert property (
    s_rev_done |-> !ag_eff_addr[0] && !ag_pointer_next[0]) else $error("odd reversed address");
  a_rev_beats_mod: assert property (
    s_rev_done |-> !ag_modulo_apply) else $error("modulo applied over reversal");
  a_tbl_read_path: assert property (
    live == 2'h3 && tbl_req && (tbl_op == 3'h0 || tbl_op == 3'h1 || tbl_op == 3'h4)
    |=> s_tbl_read) else $error("table read did not complete");
  a_tbl_page_addr: assert property (
    live == 2'h3 && tbl_req && tbl_op < 3'h5 |=> prog_addr[15:0] == $past(tbl_eff_addr))
    else $error("table address low part wrong");
  a_config_decode: assert property (
    prog_rd || prog_wr |-> prog_config == prog_addr[23]) else $error("config space decode");
  a_window_refused: assert property (
    live == 2'h3 && tbl_req && tbl_op == 3'h5 |=> tbl_refused && !prog_wr)
    else $error("window write not refused");
  a_high_write_mask: assert property (
    live == 2'h3 && tbl_req && tbl_op == 3'h3 |=> prog_wr && prog_wmask[1:0] == 2'h0)
    else $error("high write touches low bits");
  a_pc_step_two: assert property (
    live == 2'h3 && pc_advance && !pc_load |=> prog_counter == $past(prog_counter) + 24'h2)
    else $error("counter step not two");
endmodule
bind batg_top batg_checker u_checker (.pclk, .presetn, .ag_req, .ag_write, .ag_x_space,
  .ag_word, .ag_mode, .ag_done, .ag_eff_addr, .ag_pointer_next, .ag_bitrev_used,
  .ag_modulo_apply, .tbl_req, .tbl_op, .tbl_eff_addr, .tbl_rvalid, .tbl_refused, .prog_rd,
  .prog_wr, .prog_addr, .prog_config, .prog_wmask, .pc_advance, .pc_load, .prog_counter);
`default_nettype wire

// file: testbench/batg_prog_mem.sv
`timescale 1ns/100ps
`default_nettype none
module batg_prog_mem (
  // Program memory port
  input wire logic pclk,
  input wire logic prog_rd,
  input wire logic prog_wr,
  input wire logic [23:0] prog_addr,
  input wire logic [23:0] prog_wdata,
  input wire logic [2:0] prog_wmask,
  output logic [23:0] prog_rdata
);
  // Small window: the byte-select bit does not pick a word
  logic [23:0] mem [16];
  logic [23:0] last;
  logic [3:0] idx;
  assign idx = prog_addr[4:1];
  // Idle bus shows the inverse of the last word so stale data never passes
  assign prog_rdata = prog_rd ? mem[idx] : ~last;
  initial last = 24'h000000;
  initial for (int i = 0; i < 16; i++) mem[i] = 24'h000000;
  always @(posedge pclk) begin
    if (prog_rd) last <= mem[idx];
    for (int b = 0; b < 3; b++) begin
      if (prog_wr && prog_wmask[b]) begin
        mem[idx][b*8+:8] <= prog_wdata[b*8+:8];
      end
    end
  end
endmodule
`default_nettype wire

// file: testbench/batg_top_test.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
  $display("mismatch at %0t: got %h expected %h", $time, (a), (b)); end end
module batg_top_test
  import batg_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic ag_req, ag_write, ag_x_space, ag_word, ag_modulo_en, ag_done, ag_pointer_update;
  logic ag_bitrev_used, ag_modulo_apply, tbl_req, tbl_byte, tbl_rvalid, tbl_refused, er;
  logic [2:0] ag_mode, tbl_op, prog_wmask, t_acc, t_mask;
  logic [3:0] ag_reg_index;
  logic [15:0] ag_pointer, ag_offset, ag_eff_addr, ag_pointer_next, tbl_eff_addr, ptr, exp;
  logic [15:0] tbl_wdata, tbl_rdata, t_rd;
  logic prog_rd, prog_wr, prog_config, pc_advance, pc_load, t_cfg, t_rv;
  logic [23:0] prog_addr, prog_wdata, prog_rdata, pc_load_value, prog_counter, t_addr;
  logic [9:0] neg [7];
  int checked, failures;
  batg_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .ag_req, .ag_write, .ag_x_space, .ag_word, .ag_mode, .ag_reg_index, .ag_pointer,
    .ag_offset, .ag_modulo_en, .ag_done, .ag_eff_addr, .ag_pointer_next, .ag_pointer_update,
    .ag_bitrev_used, .ag_modulo_apply, .tbl_req, .tbl_op, .tbl_byte, .tbl_eff_addr, .tbl_wdata,
    .tbl_rvalid, .tbl_rdata, .tbl_refused, .prog_rd, .prog_wr, .prog_addr, .prog_config,
    .prog_wdata, .prog_wmask, .prog_rdata, .pc_advance, .pc_load, .pc_load_value, .prog_counter);
  batg_prog_mem u_mem (.pclk, .prog_rd, .prog_wr, .prog_addr, .prog_wdata, .prog_wmask,
    .prog_rdata);
  always #5 pclk = ~pclk;
  //////////////////////////////
  task automatic give_verdict;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      failures++;
      give_verdict();
    end
    {rd, er} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask
  task automatic ag(input logic [9:0] f, input logic [15:0] p, input logic m);
    @(posedge pclk);
    {ag_req, ag_write, ag_x_space, ag_word, ag_mode, ag_reg_index, ag_pointer, ag_modulo_en}
      <= {1'b1, f, p, m};
    @(posedge pclk);
    ag_req <= 1'b0;
    @(posedge pclk);
    `CHK(ag_done, 1'b1)
  endtask
  task automatic tbl(input logic [2:0] op, input logic bm, input logic [15:0] a,
    input logic [15:0] wd);
    @(posedge pclk);
    {tbl_req, tbl_op, tbl_byte, tbl_eff_addr, tbl_wdata} <= {1'b1, op, bm, a, wd};
    @(posedge pclk);
    tbl_req <= 1'b0;
    @(posedge pclk);
    {t_acc, t_cfg, t_mask, t_addr} =
      {prog_rd, prog_wr, tbl_refused, prog_config, prog_wmask, prog_addr};
    @(posedge pclk);
    {t_rv, t_rd} = {tbl_rvalid, tbl_rdata};
  endtask
  // Carries run from the top bit down, which walks the buffer in reversed order
  function automatic logic [15:0] rc_add(input logic [15:0] a, input logic [15:0] b);
    logic [15:0] ra, rb, s, r;
    for (int i = 0; i < 16; i++) begin
      ra[i] = a[15-i];
      rb[i] = b[15-i];
    end
    s = ra + rb;
    for (int i = 0; i < 16; i++) begin
      r[i] = s[15-i];
    end
    return r;
  endfunction
  //////////////////////////////
  task automatic t_regs;
    apb(1'b0, BATG_OFF_BITREV_CONTROL, 32'h0);
    `CHK(rd, 32'h00000000)
    apb(1'b0, BATG_OFF_ADDR_MODE, 32'h0);
    `CHK(rd[11:8], 4'hF)
    apb(1'b1, BATG_OFF_TABLE_PAGE, 32'h000000A5);
    apb(1'b0, BATG_OFF_TABLE_PAGE, 32'h0);
    `CHK(rd, 32'h000000A5)
    apb(1'b0, 8'h14, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0})
  endtask
  task automatic t_bitrev;
    apb(1'b1, BATG_OFF_BITREV_CONTROL, 32'h00008008);
    apb(1'b1, BATG_OFF_ADDR_MODE, 32'h00000300);
    ptr = 16'h1000;
    for (int i = 0; i < 4; i++) begin
      ag({3'b111, BATG_AM_POST_INC, 4'h3}, ptr, 1'b1);
      exp = rc_add(ptr, 16'h0010) & 16'hFFFE;
      `CHK(ag_pointer_update, 1'b1)
      `CHK({ag_bitrev_used, ag_modulo_apply}, 2'b10)
      `CHK(ag_eff_addr, ptr)
      `CHK(ag_pointer_next, exp)
      ptr = exp;
    end
    `CHK(ptr, 16'h1004)
    ag({3'b111, BATG_AM_PRE_INC, 4'h3}, 16'h1010, 1'b0);
    `CHK(ag_eff_addr, 16'h1008)
    neg = '{{3'b011, 3'h1, 4'h3}, {3'b101, 3'h1, 4'h3}, {3'b110, 3'h1, 4'h3},
      {3'b111, 3'h0, 4'h3}, {3'b111, 3'h3, 4'h3}, {3'b111, 3'h1, 4'h4}, {3'b111, 3'h4, 4'h3}};
    for (int i = 0; i < 7; i++) begin
      ag(neg[i], 16'h1000, 1'b1);
      `CHK({ag_bitrev_used, ag_modulo_apply}, 2'b01)
      // Normal step of 2: indirect keeps the pointer, decrements go down
      exp = (neg[i][6:4] == 3'h0) ? 16'h1000 : 16'h1002;
      if (neg[i][6:4] > 3'h2) begin
        exp = 16'h0FFE;
      end
      `CHK(ag_pointer_next, exp)
    end
    apb(1'b1, BATG_OFF_ADDR_MODE, 32'h00000F00);
    ag({3'b111, 3'h1, 4'hF}, 16'h1000, 1'b0);
    `CHK(ag_bitrev_used, 1'b0)
    apb(1'b1, BATG_OFF_ADDR_MODE, 32'h00000300);
    apb(1'b1, BATG_OFF_BITREV_CONTROL, 32'h00000008);
    ag({3'b111, 3'h1, 4'h3}, 16'h1000, 1'b0);
    `CHK(ag_bitrev_used, 1'b0)
  endtask
  task automatic t_table;
    apb(1'b1, BATG_OFF_TABLE_PAGE, 32'h00000001);
    tbl(BATG_TOP_WRITE_LOW, 1'b0, 16'h0002, 16'hBEEF);
    `CHK({t_acc, t_mask, t_cfg, t_addr}, {3'b010, 3'b011, 1'b0, 24'h010002})
    tbl(BATG_TOP_WRITE_HIGH, 1'b0, 16'h0002, 16'h00A5);
    `CHK(t_mask, 3'b100)
    tbl(BATG_TOP_READ_LOW, 1'b0, 16'h0002, 16'h0);
    `CHK({t_rv, t_rd}, {1'b1, 16'hBEEF})
    tbl(BATG_TOP_READ_LOW, 1'b1, 16'h0003, 16'h0);
    `CHK(t_rd[7:0], 8'hBE)
    tbl(BATG_TOP_READ_LOW, 1'b1, 16'h0002, 16'h0);
    `CHK(t_rd[7:0], 8'hEF)
    tbl(BATG_TOP_READ_HIGH, 1'b0, 16'h0002, 16'h0);
    `CHK(t_rd, 16'h00A5)
    tbl(BATG_TOP_READ_HIGH, 1'b1, 16'h0002, 16'h0);
    `CHK(t_rd, 16'h00A5)
    tbl(BATG_TOP_READ_HIGH, 1'b1, 16'h0003, 16'h0);
    `CHK(t_rd, 16'h0000)
    tbl(BATG_TOP_WINDOW_WRITE, 1'b0, 16'h0002, 16'h1234);
    `CHK(t_acc, 3'b001)
    tbl(3'h7, 1'b0, 16'h0002, 16'h0);
    `CHK(t_acc, 3'b001)
    tbl(BATG_TOP_WINDOW_READ, 1'b0, 16'h0003, 16'h0);
    `CHK(t_rd, 16'hBEEF)
    apb(1'b1, BATG_OFF_TABLE_PAGE, 32'h00000081);
    tbl(BATG_TOP_READ_LOW, 1'b0, 16'h0003, 16'h0);
    `CHK({t_acc, t_cfg, t_addr}, {3'b100, 1'b1, 24'h810003})
  endtask
  task automatic t_pc;
    @(posedge pclk);
    {pc_load, pc_load_value} <= {1'b1, 24'h000100};
    @(posedge pclk);
    {pc_load, pc_advance} <= 2'b01;
    repeat (3) @(posedge pclk);
    pc_advance <= 1'b0;
    apb(1'b0, BATG_OFF_PROG_COUNTER, 32'h0);
    `CHK(rd[23:0], 24'h000106)
  endtask
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {ag_req, ag_write, ag_x_space, ag_word, ag_mode, ag_reg_index, ag_pointer} = '0;
    {ag_offset, ag_modulo_en, tbl_req, tbl_op, tbl_byte, tbl_eff_addr, tbl_wdata} = '0;
    {pc_advance, pc_load, pc_load_value, checked, failures} = '0;
    ag_offset = 16'h0002;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_bitrev();
    t_table();
    t_pc();
    give_verdict();
  end
endmodule
`default_nettype wire
